// [shared/adr_defs.svh]
`ifndef ADR_DEFS_SVH
`define ADR_DEFS_SVH

`define ADR_OFF_ACCEL 8'h00
`define ADR_OFF_DECEL 8'h04
`define ADR_OFF_REF 8'h08
`define ADR_OFF_SACCEL 8'h0c
`define ADR_OFF_SDECEL 8'h10
`define ADR_OFF_BASE 8'h14
`define ADR_OFF_PATTERN 8'h18
`define ADR_OFF_TARGET 8'h1c
`define ADR_OFF_START 8'h20
`define ADR_OFF_GAIN_A 8'h24
`define ADR_OFF_GAIN_B 8'h28
`define ADR_OFF_FREQ 8'h2c
`define ADR_OFF_STATUS 8'h30

`define ADR_TIME_MAX 20'h57e40
`define ADR_TIME_SENTINEL 20'hf41dc
`define ADR_TIME_FLOOR 20'h00003
`define ADR_TIME_MIN_EFF 20'h00004
`define ADR_RST_TIME_SMALL 20'h001f4
`define ADR_RST_TIME_LARGE 20'h003e8

`define ADR_FREQ_MIN 16'h0064
`define ADR_FREQ_MAX 16'h9c40
`define ADR_RST_REF_FREQ 16'h1388
`define ADR_RST_BASE_FREQ 16'h1388
`define ADR_START_FREQ_MAX 16'h1770
`define ADR_RST_START_FREQ 16'h0032
`define ADR_START_FREQ_LOW 16'h0001
`define ADR_RST_GAIN_FREQ 16'h1388

`define ADR_PAT_LINEAR 2'h0
`define ADR_PAT_S_A 2'h1
`define ADR_PAT_S_B 2'h2

`define ADR_SA_NUM_K 4'h9
`define ADR_SA_QUAD_K 4'h4
`define ADR_SA_LIN_K 4'h5
`define ADR_FRAC_BITS 16

`define ADR_TICK_TIME_US 10000
`define ADR_CLK_MHZ 100
`define ADR_TICK_CYCLES (`ADR_TICK_TIME_US * `ADR_CLK_MHZ)
`define ADR_DIV_LAST 7'h47

`endif

// [shared/adr_pkg.sv]
package adr_pkg;

    typedef enum logic [1:0] {
        ADR_IDLE = 2'b00,
        ADR_ACCEL = 2'b01,
        ADR_HOLD = 2'b10,
        ADR_DECEL = 2'b11
    } adr_ramp_t;

    typedef enum logic {
        ADR_DIV_IDLE = 1'b0,
        ADR_DIV_RUN = 1'b1
    } adr_div_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } adr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } adr_apb_rsp_t;

    typedef struct packed {
        logic [19:0] accel;
        logic [19:0] decel;
        logic [19:0] saccel;
        logic [19:0] sdecel;
        logic [15:0] ref_f;
        logic [15:0] base_f;
        logic [15:0] target;
        logic [15:0] start_f;
        logic [15:0] gain_a;
        logic [15:0] gain_b;
        logic [1:0] pattern;
        logic [31:0] freq_acc;
        logic [31:0] rate;
        logic [19:0] tick_cnt;
        adr_ramp_t ramp;
        logic [31:0] prdata;
        logic pslverr;
        logic rsp_ready;
        logic div_go;
    } adr_state_t;

    typedef struct packed {
        adr_div_st_t st;
        logic [6:0] cnt;
        logic [71:0] num;
        logic [55:0] den;
        logic [56:0] rem;
        logic [71:0] quo;
        logic [31:0] q;
        logic done;
    } adr_div_state_t;

endpackage

// [hw/adr_div.sv]
`timescale 1ns/1ns
`include "adr_defs.svh"

// Restoring divider, one quotient bit per enabled cycle; results above 32 bits saturate.
module adr_div import adr_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic go_in,
    input wire logic [71:0] num_in,
    input wire logic [55:0] den_in,
    output logic [31:0] quot_out,
    output logic done_out,
    output logic busy_out
);

    adr_div_state_t s;
    adr_div_state_t next_s;

    always_comb begin
        logic [56:0] shifted;
        logic [71:0] quo_new;
        shifted = {s.rem[55:0], s.num[71]};
        quo_new = {s.quo[70:0], 1'b0};
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            ADR_DIV_IDLE: begin
                if (go_in) begin
                    next_s.st = ADR_DIV_RUN;
                    next_s.num = num_in;
                    next_s.den = den_in;
                    next_s.rem = 57'h0;
                    next_s.quo = 72'h0;
                    next_s.cnt = 7'h00;
                end
            end
            ADR_DIV_RUN: begin
                if (shifted >= {1'b0, s.den}) begin
                    next_s.rem = shifted - {1'b0, s.den};
                    quo_new[0] = 1'b1;
                end else begin
                    next_s.rem = shifted;
                end
                next_s.quo = quo_new;
                next_s.num = {s.num[70:0], 1'b0};
                next_s.cnt = s.cnt + 7'h01;
                if (s.cnt == `ADR_DIV_LAST) begin
                    next_s.st = ADR_DIV_IDLE;
                    next_s.done = 1'b1;
                    next_s.q = (|quo_new[71:32]) ? 32'hffffffff : quo_new[31:0];
                end
            end
            default: begin
                next_s.st = ADR_DIV_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s <= '0;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign quot_out = s.q;
    assign done_out = s.done;
    assign busy_out = (s.st == ADR_DIV_RUN);

endmodule

// [hw/adr_ramp_timer.sv]
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "adr_defs.svh"

module adr_ramp_timer import adr_pkg::*; #(
    parameter bit LARGE_VARIANT = 1'b0,
    parameter int TICK_CYCLES = `ADR_TICK_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire adr_apb_req_t apb_req_in,
    output adr_apb_rsp_t apb_rsp_out,
    input wire logic start_in,
    input wire logic second_set_select_in,
    output logic [15:0] freq_cmd_out
);

    localparam logic [19:0] RST_TIME = LARGE_VARIANT ? `ADR_RST_TIME_LARGE : `ADR_RST_TIME_SMALL;
    localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

    localparam adr_state_t RST_S = '{
        accel: RST_TIME,
        decel: RST_TIME,
        saccel: RST_TIME,
        sdecel: `ADR_TIME_SENTINEL,
        ref_f: `ADR_RST_REF_FREQ,
        base_f: `ADR_RST_BASE_FREQ,
        target: 16'h0000,
        start_f: `ADR_RST_START_FREQ,
        gain_a: `ADR_RST_GAIN_FREQ,
        gain_b: `ADR_RST_GAIN_FREQ,
        pattern: `ADR_PAT_LINEAR,
        freq_acc: 32'h00000000,
        rate: 32'h00000000,
        tick_cnt: 20'h00000,
        ramp: ADR_IDLE,
        prdata: 32'h00000000,
        pslverr: 1'b0,
        rsp_ready: 1'b0,
        div_go: 1'b0
    };

    function automatic logic [19:0] eff_time(input logic [19:0] t);
        eff_time = (t <= `ADR_TIME_FLOOR) ? `ADR_TIME_MIN_EFF : t;
    endfunction

    function automatic logic [31:0] sq(input logic [15:0] f);
        sq = 32'(f) * 32'(f);
    endfunction

    function automatic logic wr_ok(input logic [7:0] a, input logic [31:0] d);
        case (a)
            `ADR_OFF_ACCEL, `ADR_OFF_DECEL, `ADR_OFF_SACCEL: begin
                wr_ok = d <= 32'(`ADR_TIME_MAX);
            end
            `ADR_OFF_SDECEL: begin
                wr_ok = (d <= 32'(`ADR_TIME_MAX)) || (d == 32'(`ADR_TIME_SENTINEL));
            end
            `ADR_OFF_REF, `ADR_OFF_BASE: begin
                wr_ok = (d >= 32'(`ADR_FREQ_MIN)) && (d <= 32'(`ADR_FREQ_MAX));
            end
            `ADR_OFF_PATTERN: begin
                wr_ok = d <= 32'(`ADR_PAT_S_B);
            end
            `ADR_OFF_START: begin
                wr_ok = d <= 32'(`ADR_START_FREQ_MAX);
            end
            `ADR_OFF_TARGET, `ADR_OFF_GAIN_A, `ADR_OFF_GAIN_B: begin
                wr_ok = d[31:16] == 16'h0000;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    endfunction

    adr_state_t s;
    adr_state_t next_s;

    logic [15:0] cur;
    logic [15:0] dest;
    logic [31:0] dest_fx;
    logic going_up;
    logic [19:0] raw_acc;
    logic [19:0] sdec_eff;
    logic [19:0] raw_dec;
    logic [19:0] t_act;
    logic [15:0] f_ramp;
    logic sa_high;
    logic [15:0] span;
    logic [71:0] div_num;
    logic [55:0] div_den;
    logic [31:0] div_q;
    logic div_done;
    logic div_busy;
    logic tick;
    logic [32:0] up_sum;
    logic setup;
    logic access;
    logic wr_strobe;

    assign cur = s.freq_acc[31:16];
    assign dest = (start_in && s.target >= s.start_f) ? s.target : 16'h0000;
    assign dest_fx = {dest, 16'h0000};
    assign going_up = dest_fx > s.freq_acc;
    assign raw_acc = second_set_select_in ? s.saccel : s.accel;
    assign sdec_eff = (s.sdecel == `ADR_TIME_SENTINEL) ? s.saccel : s.sdecel;
    assign raw_dec = second_set_select_in ? sdec_eff : s.decel;
    assign t_act = eff_time(going_up ? raw_acc : raw_dec);
    assign f_ramp = going_up ? dest : cur;
    assign sa_high = (s.pattern == `ADR_PAT_S_A) && (f_ramp >= s.base_f);
    // S-pattern B keeps the linear time base; only pattern A re-scales against base frequency.
    assign span = (s.pattern == `ADR_PAT_S_A) ? s.base_f : s.ref_f;

    // Rate is frequency span per tick in 16.16 fixed point; at or above base in S-pattern A it is f / t(f).
    assign div_num = sa_high
        ? (72'(f_ramp) * 72'(sq(s.base_f)) * 72'(`ADR_SA_NUM_K)) << `ADR_FRAC_BITS
        : 72'({span, 16'h0000});
    assign div_den = sa_high
        ? 56'(t_act) * (56'(sq(f_ramp)) * 56'(`ADR_SA_QUAD_K) + 56'(sq(s.base_f)) * 56'(`ADR_SA_LIN_K))
        : 56'(t_act);

    assign tick = (s.tick_cnt == TICK_LAST);
    assign up_sum = {1'b0, s.freq_acc} + {1'b0, s.rate};
    assign setup = apb_req_in.psel && !apb_req_in.penable;
    assign access = apb_req_in.psel && apb_req_in.penable && s.rsp_ready;
    assign wr_strobe = ce_in && access && apb_req_in.pwrite;

    adr_div u_div (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .go_in(s.div_go),
        .num_in(div_num),
        .den_in(div_den),
        .quot_out(div_q),
        .done_out(div_done),
        .busy_out(div_busy)
    );

    always_comb begin
        logic [31:0] rd;
        logic rd_hit;
        rd = 32'h00000000;
        rd_hit = 1'b1;
        next_s = s;
        next_s.div_go = 1'b0;
        case (apb_req_in.paddr)
            `ADR_OFF_ACCEL: rd = 32'(s.accel);
            `ADR_OFF_DECEL: rd = 32'(s.decel);
            `ADR_OFF_REF: rd = 32'(s.ref_f);
            `ADR_OFF_SACCEL: rd = 32'(s.saccel);
            `ADR_OFF_SDECEL: rd = 32'(s.sdecel);
            `ADR_OFF_BASE: rd = 32'(s.base_f);
            `ADR_OFF_PATTERN: rd = 32'(s.pattern);
            `ADR_OFF_TARGET: rd = 32'(s.target);
            `ADR_OFF_START: rd = 32'(s.start_f);
            `ADR_OFF_GAIN_A: rd = 32'(s.gain_a);
            `ADR_OFF_GAIN_B: rd = 32'(s.gain_b);
            `ADR_OFF_FREQ: rd = 32'(cur);
            `ADR_OFF_STATUS: rd = {29'h0, second_set_select_in, s.ramp};
            default: rd_hit = 1'b0;
        endcase
        // Answer is prepared in the setup cycle so read data comes from a flop.
        if (setup) begin
            next_s.rsp_ready = 1'b1;
            next_s.pslverr = apb_req_in.pwrite ? !wr_ok(apb_req_in.paddr, apb_req_in.pwdata) : !rd_hit;
            next_s.prdata = apb_req_in.pwrite ? 32'h00000000 : rd;
        end
        // Writes land only at the access edge, so a refused value leaves the register untouched.
        if (access) begin
            next_s.rsp_ready = 1'b0;
            if (apb_req_in.pwrite && !s.pslverr) begin
                case (apb_req_in.paddr)
                    `ADR_OFF_ACCEL: next_s.accel = apb_req_in.pwdata[19:0];
                    `ADR_OFF_DECEL: next_s.decel = apb_req_in.pwdata[19:0];
                    `ADR_OFF_REF: next_s.ref_f = apb_req_in.pwdata[15:0];
                    `ADR_OFF_SACCEL: next_s.saccel = apb_req_in.pwdata[19:0];
                    `ADR_OFF_SDECEL: next_s.sdecel = apb_req_in.pwdata[19:0];
                    `ADR_OFF_BASE: next_s.base_f = apb_req_in.pwdata[15:0];
                    `ADR_OFF_PATTERN: next_s.pattern = apb_req_in.pwdata[1:0];
                    `ADR_OFF_TARGET: next_s.target = apb_req_in.pwdata[15:0];
                    `ADR_OFF_START: next_s.start_f = apb_req_in.pwdata[15:0];
                    `ADR_OFF_GAIN_A: next_s.gain_a = apb_req_in.pwdata[15:0];
                    `ADR_OFF_GAIN_B: next_s.gain_b = apb_req_in.pwdata[15:0];
                    default: next_s.pslverr = s.pslverr;
                endcase
            end
        end
        // The divider runs back to back so the rate tracks settings and direction.
        // A direction change therefore runs on the old rate until the next division ends.
        if (!div_busy && !s.div_go) begin
            next_s.div_go = 1'b1;
        end
        if (div_done) begin
            next_s.rate = div_q;
        end
        next_s.tick_cnt = tick ? 20'h00000 : s.tick_cnt + 20'h00001;
        if (tick) begin
            if (s.freq_acc == 32'h00000000 && dest != 16'h0000) begin
                // A zero starting frequency still starts at the lowest step.
                next_s.freq_acc = {(s.start_f == 16'h0000) ? `ADR_START_FREQ_LOW : s.start_f, 16'h0000};
            end else if (going_up) begin
                next_s.freq_acc = (up_sum >= {1'b0, dest_fx}) ? dest_fx : up_sum[31:0];
            end else if (dest_fx < s.freq_acc) begin
                next_s.freq_acc = (s.freq_acc - dest_fx > s.rate) ? s.freq_acc - s.rate : dest_fx;
            end
        end
        if (s.freq_acc == 32'h00000000 && dest == 16'h0000) begin
            next_s.ramp = ADR_IDLE;
        end else if (going_up) begin
            next_s.ramp = ADR_ACCEL;
        end else if (dest_fx < s.freq_acc) begin
            next_s.ramp = ADR_DECEL;
        end else begin
            next_s.ramp = ADR_HOLD;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s <= RST_S;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    assign apb_rsp_out = '{
        prdata: s.prdata,
        pready: ce_in && s.rsp_ready,
        pslverr: s.pslverr
    };
    assign freq_cmd_out = cur;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_min_time_floor: assert property (
        ((going_up ? raw_acc : raw_dec) <= `ADR_TIME_FLOOR) |-> (t_act == `ADR_TIME_MIN_EFF)
    ) else $error("Short ramp time not raised to minimum.");

    a_second_accel_used: assert property (
        (second_set_select_in && going_up && s.saccel > `ADR_TIME_FLOOR) |-> (t_act == s.saccel)
    ) else $error("Second accel time not used while selected.");

    a_sentinel_follow: assert property (
        (second_set_select_in && !going_up && s.sdecel == `ADR_TIME_SENTINEL && s.saccel > `ADR_TIME_FLOOR)
        |-> (t_act == s.saccel)
    ) else $error("Sentinel decel does not follow second accel.");

    a_time_range: assert property (
        (s.accel <= `ADR_TIME_MAX) && (s.decel <= `ADR_TIME_MAX) && (s.saccel <= `ADR_TIME_MAX)
    ) else $error("Ramp time setting out of range.");

    a_sdecel_range: assert property (
        (s.sdecel <= `ADR_TIME_MAX) || (s.sdecel == `ADR_TIME_SENTINEL)
    ) else $error("Second decel time out of range.");

    a_ref_range: assert property (
        (s.ref_f >= `ADR_FREQ_MIN) && (s.ref_f <= `ADR_FREQ_MAX)
    ) else $error("Reference frequency out of range.");

    a_decel_write_err: assert property (
        (ce_in && setup && apb_req_in.pwrite && apb_req_in.paddr == `ADR_OFF_DECEL
         && apb_req_in.pwdata > 32'(`ADR_TIME_MAX)) |=> (s.pslverr && s.decel == $past(s.decel))
    ) else $error("Out of range decel write not refused.");

    a_gain_keep: assert property (
        (apb_rsp_out.pready && access && apb_req_in.pwrite && apb_req_in.paddr == `ADR_OFF_REF)
        |=> ($stable(s.gain_a) && $stable(s.gain_b))
    ) else $error("Gain frequency changed by reference write.");

    a_start_jump: assert property (
        (ce_in && tick && s.freq_acc == 32'h00000000 && dest != 16'h0000)
        |=> (freq_cmd_out == (($past(s.start_f) == 16'h0000) ? `ADR_START_FREQ_LOW : $past(s.start_f)))
    ) else $error("Output did not start at starting frequency.");

    a_accel_step: assert property (
        (ce_in && tick && going_up && s.freq_acc != 32'h00000000 && s.rate != 32'h00000000)
        |=> (s.freq_acc > $past(s.freq_acc)) && (s.freq_acc - $past(s.freq_acc) <= $past(s.rate))
    ) else $error("Accel step not bounded by rate.");

    a_decel_step: assert property (
        (ce_in && tick && !going_up && dest_fx < s.freq_acc && s.rate != 32'h00000000)
        |=> (s.freq_acc < $past(s.freq_acc)) && ($past(s.freq_acc) - s.freq_acc <= $past(s.rate))
    ) else $error("Decel step not bounded by rate.");

    a_accel_refused: assert property (
        (wr_strobe && apb_req_in.paddr == `ADR_OFF_ACCEL && apb_req_in.pwdata > 32'(`ADR_TIME_MAX))
        |-> s.pslverr ##1 (s.accel == $past(s.accel))
    ) else $error("Out of range accel write not refused.");

    a_ref_refused: assert property (
        (wr_strobe && apb_req_in.paddr == `ADR_OFF_REF
         && (apb_req_in.pwdata < 32'(`ADR_FREQ_MIN) || apb_req_in.pwdata > 32'(`ADR_FREQ_MAX)))
        |-> s.pslverr ##1 (s.ref_f == $past(s.ref_f))
    ) else $error("Out of range reference write not refused.");

    a_sdecel_refused: assert property (
        (wr_strobe && apb_req_in.paddr == `ADR_OFF_SDECEL && apb_req_in.pwdata > 32'(`ADR_TIME_MAX)
         && apb_req_in.pwdata != 32'(`ADR_TIME_SENTINEL))
        |-> s.pslverr ##1 (s.sdecel == $past(s.sdecel))
    ) else $error("Out of range second decel write not refused.");

    a_accel_lands: assert property (
        (wr_strobe && apb_req_in.paddr == `ADR_OFF_ACCEL && !s.pslverr)
        |=> (s.accel == $past(apb_req_in.pwdata[19:0]))
    ) else $error("Accepted accel write did not land.");

    a_hold_at_dest: assert property (
        (ce_in && tick && s.freq_acc == dest_fx && dest != 16'h0000) |=> $stable(s.freq_acc)
    ) else $error("Output moved while at its destination.");

    a_idle_at_rest: assert property (
        (ce_in && s.freq_acc == 32'h00000000 && dest == 16'h0000) |=> (s.ramp == ADR_IDLE)
    ) else $error("Ramp state not idle at rest.");

    c_second_accel: cover property (ce_in && tick && second_set_select_in && going_up);
    c_sentinel_decel: cover property (ce_in && tick && second_set_select_in && !going_up
                                      && s.sdecel == `ADR_TIME_SENTINEL && dest_fx < s.freq_acc);
    c_s_pattern_high: cover property (div_done && sa_high);
    c_min_time: cover property (ce_in && tick && going_up && t_act == `ADR_TIME_MIN_EFF);
    c_ref_write: cover property (apb_rsp_out.pready && access && apb_req_in.paddr == `ADR_OFF_REF);

endmodule

// [tb/adr_op_model.sv]
`timescale 1ns/1ns

// Operator and power-stage stand-in: requests leave it just after a rising edge.
module adr_op_model (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic run_req_in,
    input wire logic set2_req_in,
    input wire logic [15:0] freq_cmd_in,
    output logic start_out,
    output logic second_set_select_out,
    output logic [15:0] last_freq_out
);
    logic run_q;
    logic set2_q;
    logic [15:0] freq_q;

    assign start_out = run_q;
    assign second_set_select_out = set2_q;
    assign last_freq_out = freq_q;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_q <= 1'b0;
            set2_q <= 1'b0;
            freq_q <= 16'h0000;
        end else begin
            run_q <= run_req_in;
            set2_q <= set2_req_in;
            freq_q <= freq_cmd_in;
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ns
`include "adr_defs.svh"

module testbench import adr_pkg::*;;
    localparam int TICK = 100;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic run_req = 1'b0;
    logic set2_req = 1'b0;
    logic start_in;
    logic second_set_select_in;
    adr_apb_req_t req = '0;
    adr_apb_rsp_t rsp;
    logic [15:0] freq_cmd_out;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    adr_ramp_timer #(.LARGE_VARIANT(1'b0), .TICK_CYCLES(TICK)) dut (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .apb_req_in(req),
        .apb_rsp_out(rsp),
        .start_in(start_in),
        .second_set_select_in(second_set_select_in),
        .freq_cmd_out(freq_cmd_out)
    );

    adr_op_model model (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .run_req_in(run_req),
        .set2_req_in(set2_req),
        .freq_cmd_in(freq_cmd_out),
        .start_out(start_in),
        .second_set_select_out(second_set_select_in),
        .last_freq_out()
    );

    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
                       output logic [31:0] q);
        @(posedge sys_clk_in);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        @(posedge sys_clk_in);
        while (rsp.pready !== 1'b1) begin
            @(posedge sys_clk_in);
        end
        q = rsp.prdata;
        check1(rsp.pslverr, e);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] q;
        apb(1'b1, a, d, e, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, e, q);
        if (!e) begin
            check32(q, exp);
        end
    endtask

    task automatic do_reset();
        run_req <= 1'b0;
        set2_req <= 1'b0;
        arst_n_in <= 1'b0;
        repeat (16) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        repeat (100) @(posedge sys_clk_in);
    endtask

    // Compares the change of the command over ten ticks; samples share one phase.
    task automatic slope(input logic [15:0] exp, input logic up);
        logic [15:0] a;
        logic [15:0] d;
        repeat (3 * TICK) @(posedge sys_clk_in);
        a = freq_cmd_out;
        repeat (10 * TICK) @(posedge sys_clk_in);
        d = up ? freq_cmd_out - a : a - freq_cmd_out;
        check32({16'h0000, d}, {16'h0000, exp});
    endtask

    task automatic test_registers();
        rd(`ADR_OFF_ACCEL, 32'h1f4, 1'b0);
        rd(`ADR_OFF_DECEL, 32'h1f4, 1'b0);
        rd(`ADR_OFF_REF, 32'h1388, 1'b0);
        rd(`ADR_OFF_SACCEL, 32'h1f4, 1'b0);
        rd(`ADR_OFF_SDECEL, 32'hf41dc, 1'b0);
        wr(`ADR_OFF_ACCEL, 32'h57e41, 1'b1);
        rd(`ADR_OFF_ACCEL, 32'h1f4, 1'b0);
        wr(`ADR_OFF_ACCEL, 32'h57e40, 1'b0);
        rd(`ADR_OFF_ACCEL, 32'h57e40, 1'b0);
        wr(`ADR_OFF_DECEL, 32'h57e41, 1'b1);
        wr(`ADR_OFF_REF, 32'h63, 1'b1);
        wr(`ADR_OFF_REF, 32'h9c41, 1'b1);
        wr(`ADR_OFF_REF, 32'h64, 1'b0);
        rd(`ADR_OFF_REF, 32'h64, 1'b0);
        wr(`ADR_OFF_SDECEL, 32'h57e41, 1'b1);
        wr(`ADR_OFF_SDECEL, 32'h57e40, 1'b0);
        rd(`ADR_OFF_SDECEL, 32'h57e40, 1'b0);
        wr(`ADR_OFF_GAIN_A, 32'h1234, 1'b0);
        wr(`ADR_OFF_REF, 32'h9c40, 1'b0);
        rd(`ADR_OFF_GAIN_A, 32'h1234, 1'b0);
        rd(`ADR_OFF_GAIN_B, 32'h1388, 1'b0);
        wr(`ADR_OFF_FREQ, 32'h0, 1'b1);
        rd(8'h40, 32'h0, 1'b1);
    endtask

    task automatic test_linear();
        logic [15:0] f;
        do_reset();
        wr(`ADR_OFF_PATTERN, 32'h2, 1'b0);
        wr(`ADR_OFF_ACCEL, 32'h64, 1'b0);
        wr(`ADR_OFF_DECEL, 32'hc8, 1'b0);
        wr(`ADR_OFF_START, 32'h12c, 1'b0);
        wr(`ADR_OFF_TARGET, 32'h1388, 1'b0);
        run_req <= 1'b1;
        while (freq_cmd_out == 16'h0000) begin
            @(posedge sys_clk_in);
        end
        check32({16'h0000, freq_cmd_out}, 32'h12c);
        rd(`ADR_OFF_FREQ, 32'h12c, 1'b0);
        slope(16'h01f4, 1'b1);
        ce_in <= 1'b0;
        @(posedge sys_clk_in);
        f = freq_cmd_out;
        repeat (3 * TICK) @(posedge sys_clk_in);
        check32({16'h0000, freq_cmd_out}, {16'h0000, f});
        ce_in <= 1'b1;
        run_req <= 1'b0;
        slope(16'h00fa, 1'b0);
    endtask

    task automatic test_second_set();
        do_reset();
        wr(`ADR_OFF_SACCEL, 32'hfa, 1'b0);
        wr(`ADR_OFF_TARGET, 32'h1388, 1'b0);
        set2_req <= 1'b1;
        run_req <= 1'b1;
        slope(16'h00c8, 1'b1);
        rd(`ADR_OFF_STATUS, 32'h5, 1'b0);
        repeat (60 * TICK) @(posedge sys_clk_in);
        run_req <= 1'b0;
        slope(16'h00c8, 1'b0);
        rd(`ADR_OFF_STATUS, 32'h7, 1'b0);
        wr(`ADR_OFF_SDECEL, 32'h3e8, 1'b0);
        slope(16'h0032, 1'b0);
        set2_req <= 1'b0;
        slope(16'h0064, 1'b0);
    endtask

    task automatic test_min_time(input logic [31:0] t);
        do_reset();
        wr(`ADR_OFF_ACCEL, t, 1'b0);
        wr(`ADR_OFF_TARGET, 32'h9c40, 1'b0);
        run_req <= 1'b1;
        slope(16'h30d4, 1'b1);
        repeat (30 * TICK) @(posedge sys_clk_in);
        check32({16'h0000, freq_cmd_out}, 32'h9c40);
    endtask

    task automatic test_s_pattern(input logic [31:0] base, input logic [31:0] t, input logic [15:0] exp);
        do_reset();
        wr(`ADR_OFF_PATTERN, 32'h1, 1'b0);
        wr(`ADR_OFF_BASE, base, 1'b0);
        wr(`ADR_OFF_ACCEL, t, 1'b0);
        wr(`ADR_OFF_TARGET, base * 32'h2, 1'b0);
        if (exp == 16'h00fa) begin
            wr(`ADR_OFF_TARGET, base - 32'h1, 1'b0);
        end
        run_req <= 1'b1;
        slope(exp, 1'b1);
    endtask

    initial begin
        do_reset();
        test_registers();
        test_linear();
        test_second_set();
        test_min_time(32'h0);
        test_min_time(32'h3);
        test_s_pattern(32'h9c4, 32'h64, 16'h00fa);
        test_s_pattern(32'h1b58, 32'h3c, 16'h03e8);
        print_verdict();
    end
endmodule
